// *** core/wcg_map.svh ***
// register map, field positions, reset values and check constants
`ifndef WCG_MAP_SVH
`define WCG_MAP_SVH
`define WCG_CTRL_OFS 8'h00
`define WCG_RANGE_OFS 8'h04
`define WCG_RATIO_OFS 8'h08
`define WCG_OFFSET_OFS 8'h0c
`define WCG_GEAR_A_OFS 8'h10
`define WCG_GEAR_B_OFS 8'h14
`define WCG_CMD_OFS 8'h18
`define WCG_HOME_OFS 8'h1c
`define WCG_STATUS_OFS 8'h20
`define WCG_INT_STAT_OFS 8'h24
`define WCG_INT_CLR_OFS 8'h28
`define WCG_INT_EN_OFS 8'h2c
`define WCG_CMD_POS_OFS 8'h30
`define WCG_ACT_POS_OFS 8'h34
`define WCG_STEPS_OFS 8'h38
`define WCG_CTRL_MODE_LSB 0
`define WCG_CTRL_SRC_BIT 2
`define WCG_CTRL_WEN_BIT 3
`define WCG_CTRL_SMALL_BIT 4
`define WCG_CMD_CFG_BIT 0
`define WCG_CMD_PRESET_BIT 1
`define WCG_CMD_ALM_CLR_BIT 2
`define WCG_RANGE_RST 16'h000a
`define WCG_RATIO_RST 14'h1388
`define WCG_RATIO_MAX 14'h2710
`define WCG_OFFSET_RST 30'h00000000
`define WCG_GEAR_RST 32'h00000001
`define WCG_SPAN_FULL 64'h0000000000004650
`define WCG_SPAN_SMALL 64'h0000000000002328
`define WCG_STEP_SCALE 64'h00000000000003e8
`define WCG_RATIO_DIV 32'h00002710
`define WCG_IRQ_ERR 0
`define WCG_IRQ_ALM 1
`define WCG_IRQ_CHK 2
`define WCG_IRQ_PRE 3
`define WCG_IRQ_W 4
`endif

// *** core/wcg_pkg.sv ***
// types shared by the wrap coordinate generator
package wcg_pkg;
    typedef enum logic [1:0] {
        WCG_MODE_ABS = 2'h0,
        WCG_MODE_NEAR = 2'h1,
        WCG_MODE_FWD = 2'h2,
        WCG_MODE_REV = 2'h3
    } wcg_mode_e;
    typedef enum logic [4:0] {
        WCG_IDLE = 5'h01,
        WCG_C1 = 5'h02,
        WCG_C2 = 5'h04,
        WCG_C3 = 5'h08,
        WCG_DONE = 5'h10
    } wcg_chk_e;
endpackage

// *** core/wcg_divider.sv ***
// sequential restoring divider, one quotient bit per cycle
`timescale 1ns/100ps
module wcg_divider #(
    parameter int DW = 64,
    parameter int VW = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [DW-1:0] dividend,
    input wire logic [VW-1:0] divisor,
    output logic done,
    output logic [DW-1:0] quo_ff,
    output logic [VW-1:0] rem_ff
);
    // the bit counter is eight bits wide, so wider dividends are refused
    if (DW < 2 || VW < 2 || VW > DW || DW > 255) begin : g_bad_widths
        $error("wcg_divider: bad widths");
    end
    logic [DW-1:0] num_ff;
    logic [VW:0] acc_ff;
    logic [VW-1:0] den_ff;
    logic [7:0] cnt_ff;
    logic busy_ff;
    logic [VW:0] trial;
    assign trial = {acc_ff[VW-1:0], num_ff[DW-1]} - {1'b0, den_ff};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            num_ff <= '0;
            acc_ff <= '0;
            den_ff <= '0;
            cnt_ff <= 8'h00;
            busy_ff <= 1'b0;
            done <= 1'b0;
            quo_ff <= '0;
            rem_ff <= '0;
        end else begin
            done <= 1'b0;
            if (start) begin
                num_ff <= dividend;
                den_ff <= divisor;
                acc_ff <= '0;
                cnt_ff <= 8'(DW);
                busy_ff <= 1'b1;
            end else if (busy_ff) begin
                // a zero divisor leaves an all-ones quotient only if the dividend fits in VW bits; caller screens it
                if (!trial[VW]) begin
                    acc_ff <= trial;
                    num_ff <= {num_ff[DW-2:0], 1'b1};
                end else begin
                    acc_ff <= {acc_ff[VW-1:0], num_ff[DW-1]};
                    num_ff <= {num_ff[DW-2:0], 1'b0};
                end
                cnt_ff <= cnt_ff - 8'h01;
                if (cnt_ff == 8'h01) begin
                    busy_ff <= 1'b0;
                    done <= 1'b1;
                    quo_ff <= trial[VW] ? {num_ff[DW-2:0], 1'b0} : {num_ff[DW-2:0], 1'b1};
                    rem_ff <= trial[VW] ? {acc_ff[VW-2:0], num_ff[DW-1]} : trial[VW-1:0];
                end
            end
        end
    end
endmodule

// *** core/wcg_top.sv ***
// wrap coordinate generator: parameters, range check, wrapping positions
// Functional notes
// - wrap positioning mode 0 absolute, 1 nearest, 2 forward only, 3 reverse only
// - source select resets to 0 taking sensor values; 1 uses manual values
// - wrap enable 0 disables, 1 enables; resets to enabled
// - with wrap on, command position returns to zero after one wrap range
// - offset ratio accepted from 0 to 10000 hundredths percent, default 5000
// - signed offset value limited to 30-bit range, default zero
// - range valid only when 1800 (900 small frame) over range is integer
// - range times gear B over gear A times 10000 must be integer
// - wrap on with failed condition raises wrap setting error information
// - power cycle or configuration while info set escalates to alarm
// - wrap settings apply to eight wrap operations in profile position mode; cmd_pos and act_pos wrap whenever wrap is on, in any operation
// - position preset loads both positions with home offset, marks home set
// - nonzero offset ratio shifts wrap boundary negative from mechanical home
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
module wcg_top
    import wcg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] sens_range,
    input wire logic [13:0] sens_ratio,
    input wire logic [29:0] sens_offset,
    input wire logic profile_position_mode,
    input wire logic [3:0] op_code,
    input wire logic cmd_step,
    input wire logic cmd_dir,
    input wire logic act_step,
    input wire logic act_dir,
    output wcg_mode_e wrap_mode,
    output logic wrap_active,
    output logic err_info,
    output logic err_alarm,
    output logic home_set,
    output logic [31:0] cmd_pos,
    output logic [31:0] act_pos,
    output logic irq
);
    `include "wcg_map.svh"
    // ops 8..15 are the wrap positioning and wrap push-motion operations
    localparam logic [3:0] WRAP_OP_BASE = 4'h8;

    logic [4:0] ctrl_ff;
    logic [15:0] range_ff;
    logic [13:0] ratio_ff;
    logic [29:0] offset_ff;
    logic [31:0] gear_a_ff, gear_b_ff, home_ofs_ff;
    logic [`WCG_IRQ_W-1:0] int_stat_ff, int_en_ff;
    logic [31:0] prdata_ff;
    logic [15:0] s_range_m_ff, s_range_ff;
    logic [13:0] s_ratio_m_ff, s_ratio_ff;
    logic [29:0] s_off_m_ff, s_off_ff;
    logic wr, rd_setup, mapped;
    logic cfg_cmd, preset_cmd, alm_clr, param_wr;
    logic [15:0] eff_range;
    logic [13:0] eff_ratio;
    logic [29:0] eff_offset;

    assign wr = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign cfg_cmd = wr && paddr == `WCG_CMD_OFS && pwdata[`WCG_CMD_CFG_BIT];
    assign preset_cmd = wr && paddr == `WCG_CMD_OFS && pwdata[`WCG_CMD_PRESET_BIT];
    assign alm_clr = wr && paddr == `WCG_CMD_OFS && pwdata[`WCG_CMD_ALM_CLR_BIT];
    assign param_wr = wr && (paddr == `WCG_CTRL_OFS || paddr == `WCG_RANGE_OFS ||
        paddr == `WCG_RATIO_OFS || paddr == `WCG_OFFSET_OFS ||
        paddr == `WCG_GEAR_A_OFS || paddr == `WCG_GEAR_B_OFS);

    // sensor values are static after power-up, so a plain two-flop catch is enough
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_range_m_ff <= 16'h0000;
            s_range_ff <= 16'h0000;
            s_ratio_m_ff <= 14'h0000;
            s_ratio_ff <= 14'h0000;
            s_off_m_ff <= 30'h00000000;
            s_off_ff <= 30'h00000000;
        end else begin
            s_range_m_ff <= sens_range;
            s_range_ff <= s_range_m_ff;
            s_ratio_m_ff <= sens_ratio;
            s_ratio_ff <= s_ratio_m_ff;
            s_off_m_ff <= sens_offset;
            s_off_ff <= s_off_m_ff;
        end
    end

    // source select picks manual or sensor values
    assign eff_range = ctrl_ff[`WCG_CTRL_SRC_BIT] ? range_ff : s_range_ff;
    assign eff_ratio = ctrl_ff[`WCG_CTRL_SRC_BIT] ? ratio_ff : s_ratio_ff;
    assign eff_offset = ctrl_ff[`WCG_CTRL_SRC_BIT] ? offset_ff : s_off_ff;
    assign wrap_mode = wcg_mode_e'(ctrl_ff[`WCG_CTRL_MODE_LSB +: 2]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= 5'h08;
            range_ff <= `WCG_RANGE_RST;
            ratio_ff <= `WCG_RATIO_RST;
            offset_ff <= `WCG_OFFSET_RST;
            gear_a_ff <= `WCG_GEAR_RST;
            gear_b_ff <= `WCG_GEAR_RST;
            home_ofs_ff <= 32'h00000000;
            int_en_ff <= '0;
        end else if (wr) begin
            case (paddr)
                `WCG_CTRL_OFS: ctrl_ff <= pwdata[4:0];
                `WCG_RANGE_OFS: range_ff <= pwdata[15:0];
                `WCG_RATIO_OFS: begin
                    // out-of-range ratios are dropped, old value kept
                    if (pwdata <= 32'(`WCG_RATIO_MAX)) ratio_ff <= pwdata[13:0];
                end
                `WCG_OFFSET_OFS: begin
                    if (pwdata[31:29] == {3{pwdata[29]}}) offset_ff <= pwdata[29:0];
                end
                `WCG_GEAR_A_OFS: gear_a_ff <= pwdata;
                `WCG_GEAR_B_OFS: gear_b_ff <= pwdata;
                `WCG_HOME_OFS: home_ofs_ff <= pwdata;
                `WCG_INT_EN_OFS: int_en_ff <= pwdata[`WCG_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // validity check sequencer, three divisions on one shared divider
    wcg_chk_e chk_ff;
    logic pend_ff, boot_ff, v1_ff, v2_ff, chk_done;
    logic [1:0] warm_ff; // holds the first check until the sensor catch flops hold real values
    logic div_start, div_done;
    logic [63:0] div_num, div_quo;
    logic [31:0] div_den, div_rem;
    logic [31:0] steps_ff, shift_ff;
    logic signed [31:0] lo_ff, hi_ff;
    logic signed [31:0] nxt_lo, nxt_hi;
    logic valid_ff;

    always_comb begin
        div_start = 1'b0;
        div_num = 64'h0;
        div_den = 32'h0;
        case (chk_ff)
            WCG_IDLE: begin
                div_start = pend_ff && warm_ff[1];
                div_num = ctrl_ff[`WCG_CTRL_SMALL_BIT] ? `WCG_SPAN_SMALL : `WCG_SPAN_FULL;
                div_den = {16'h0000, eff_range};
            end
            WCG_C1: begin
                div_start = div_done;
                div_num = 64'(eff_range) * 64'(gear_b_ff) * `WCG_STEP_SCALE;
                div_den = gear_a_ff;
            end
            WCG_C2: begin
                div_start = div_done;
                div_num = 64'(div_quo[31:0]) * 64'(eff_ratio);
                div_den = `WCG_RATIO_DIV;
            end
            default: ;
        endcase
    end

    wcg_divider #(.DW(64), .VW(32)) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .start(div_start),
        .dividend(div_num),
        .divisor(div_den),
        .done(div_done),
        .quo_ff(div_quo),
        .rem_ff(div_rem)
    );

    // boundary pulled negative by the ratio share of the range
    assign nxt_lo = $signed({{2{eff_offset[29]}}, eff_offset}) - $signed(div_quo[31:0]);
    assign nxt_hi = nxt_lo + $signed(steps_ff) - 32'sd1;
    assign chk_done = chk_ff == WCG_DONE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chk_ff <= WCG_IDLE;
            pend_ff <= 1'b1;
            warm_ff <= 2'b00;
            v1_ff <= 1'b0;
            v2_ff <= 1'b0;
            steps_ff <= 32'h0;
            shift_ff <= 32'h0;
            lo_ff <= 32'sd0;
            hi_ff <= 32'sd0;
            valid_ff <= 1'b0;
        end else begin
            // a retrigger during a run waits and reruns with the newest values
            warm_ff <= {warm_ff[0], 1'b1};
            if (cfg_cmd || param_wr) pend_ff <= 1'b1;
            else if (chk_ff == WCG_IDLE && warm_ff[1]) pend_ff <= 1'b0;
            case (chk_ff)
                WCG_IDLE: if (pend_ff && warm_ff[1]) chk_ff <= WCG_C1;
                WCG_C1: if (div_done) begin
                    v1_ff <= eff_range != 16'h0 && div_rem == 32'h0;
                    chk_ff <= WCG_C2;
                end
                WCG_C2: if (div_done) begin
                    v2_ff <= gear_a_ff != 32'h0 && div_rem == 32'h0 &&
                        div_quo[63:31] == 33'h0;
                    steps_ff <= div_quo[31:0];
                    chk_ff <= WCG_C3;
                end
                WCG_C3: if (div_done) begin
                    shift_ff <= div_quo[31:0];
                    lo_ff <= nxt_lo;
                    hi_ff <= nxt_hi;
                    // home must sit inside the shifted range
                    valid_ff <= v1_ff && v2_ff && nxt_lo <= 32'sd0 && nxt_hi >= 32'sd0;
                    chk_ff <= WCG_DONE;
                end
                WCG_DONE: chk_ff <= WCG_IDLE;
                default: chk_ff <= WCG_IDLE;
            endcase
        end
    end

    // error information and alarm escalation
    logic boot_done_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_info <= 1'b0;
            err_alarm <= 1'b0;
            boot_ff <= 1'b1;
            boot_done_ff <= 1'b0;
        end else begin
            if (chk_done) begin
                err_info <= ctrl_ff[`WCG_CTRL_WEN_BIT] && !valid_ff;
                boot_ff <= 1'b0;
            end
            if (chk_done && boot_ff) boot_done_ff <= 1'b1;
            // info left from the last power period reappears on the power-up check
            if ((cfg_cmd && err_info) ||
                (chk_done && boot_ff && ctrl_ff[`WCG_CTRL_WEN_BIT] && !valid_ff))
                err_alarm <= 1'b1;
            else if (alm_clr)
                err_alarm <= 1'b0;
        end
    end

    assign wrap_active = ctrl_ff[`WCG_CTRL_WEN_BIT] && !err_info && boot_done_ff &&
        profile_position_mode && op_code >= WRAP_OP_BASE;

    function automatic logic [31:0] wrap_next(input logic [31:0] pos, input logic dir,
                                              input logic en, input logic signed [31:0] lo,
                                              input logic signed [31:0] hi);
        logic signed [31:0] p;
        p = $signed(pos);
        if (dir) wrap_next = (en && p >= hi) ? lo : pos + 32'h1;
        else wrap_next = (en && p <= lo) ? hi : pos - 32'h1;
    endfunction

    logic wrap_on;
    assign wrap_on = ctrl_ff[`WCG_CTRL_WEN_BIT] && !err_info && boot_done_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_pos <= 32'h0;
            act_pos <= 32'h0;
            home_set <= 1'b0;
        end else if (preset_cmd) begin
            cmd_pos <= home_ofs_ff;
            act_pos <= home_ofs_ff;
            home_set <= 1'b1;
        end else begin
            if (cmd_step) cmd_pos <= wrap_next(cmd_pos, cmd_dir, wrap_on, lo_ff, hi_ff);
            if (act_step) act_pos <= wrap_next(act_pos, act_dir, wrap_on, lo_ff, hi_ff);
        end
    end

    // sticky events, set wins over a clear in the same cycle
    logic [`WCG_IRQ_W-1:0] ev, clr;
    logic err_q_ff, alm_q_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_q_ff <= 1'b0;
            alm_q_ff <= 1'b0;
        end else begin
            err_q_ff <= err_info;
            alm_q_ff <= err_alarm;
        end
    end
    assign ev = {preset_cmd, chk_done, err_alarm && !alm_q_ff, err_info && !err_q_ff};
    assign clr = (wr && paddr == `WCG_INT_CLR_OFS) ? pwdata[`WCG_IRQ_W-1:0] : '0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) int_stat_ff <= '0;
        else int_stat_ff <= (int_stat_ff & ~clr) | ev;
    end
    assign irq = |(int_stat_ff & int_en_ff);

    // apb: read data caught in setup, zero wait states
    always_comb begin
        mapped = 1'b1;
        case (paddr)
            `WCG_CTRL_OFS, `WCG_RANGE_OFS, `WCG_RATIO_OFS, `WCG_OFFSET_OFS,
            `WCG_GEAR_A_OFS, `WCG_GEAR_B_OFS, `WCG_CMD_OFS, `WCG_HOME_OFS,
            `WCG_STATUS_OFS, `WCG_INT_STAT_OFS, `WCG_INT_CLR_OFS, `WCG_INT_EN_OFS,
            `WCG_CMD_POS_OFS, `WCG_ACT_POS_OFS, `WCG_STEPS_OFS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata_ff <= 32'h0;
        else if (rd_setup) begin
            case (paddr)
                `WCG_CTRL_OFS: prdata_ff <= {27'h0, ctrl_ff};
                `WCG_RANGE_OFS: prdata_ff <= {16'h0, range_ff};
                `WCG_RATIO_OFS: prdata_ff <= {18'h0, ratio_ff};
                `WCG_OFFSET_OFS: prdata_ff <= {{2{offset_ff[29]}}, offset_ff};
                `WCG_GEAR_A_OFS: prdata_ff <= gear_a_ff;
                `WCG_GEAR_B_OFS: prdata_ff <= gear_b_ff;
                `WCG_HOME_OFS: prdata_ff <= home_ofs_ff;
                `WCG_STATUS_OFS: prdata_ff <= {26'h0, wrap_on, !chk_done && chk_ff != WCG_IDLE,
                    home_set, err_alarm, err_info, valid_ff};
                `WCG_INT_STAT_OFS: prdata_ff <= {28'h0, int_stat_ff};
                `WCG_INT_EN_OFS: prdata_ff <= {28'h0, int_en_ff};
                `WCG_CMD_POS_OFS: prdata_ff <= cmd_pos;
                `WCG_ACT_POS_OFS: prdata_ff <= act_pos;
                `WCG_STEPS_OFS: prdata_ff <= steps_ff;
                default: prdata_ff <= 32'h0;
            endcase
        end
    end
    assign prdata = prdata_ff;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // checks
    wen_reset_a: assert property (@(posedge pclk) $rose(presetn) |->
        ctrl_ff[`WCG_CTRL_WEN_BIT] && !ctrl_ff[`WCG_CTRL_SRC_BIT])
        else $error("wrap enable or source select not at reset value");
    mode_decode_a: assert property (@(posedge pclk) disable iff (!presetn)
        wrap_mode == wcg_mode_e'(ctrl_ff[1:0]))
        else $error("wrap mode decode mismatch");
    src_pick_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_ff[`WCG_CTRL_SRC_BIT] |-> eff_range == s_range_ff)
        else $error("sensor range not used when source is sensor");
    ratio_lim_a: assert property (@(posedge pclk) disable iff (!presetn)
        ratio_ff <= `WCG_RATIO_MAX)
        else $error("offset ratio above limit");
    info_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        chk_done && ctrl_ff[`WCG_CTRL_WEN_BIT] && !valid_ff |=> err_info)
        else $error("invalid range did not raise error info");
    alarm_esc_a: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_cmd && err_info |=> err_alarm)
        else $error("configuration with error info did not raise alarm");
    preset_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        preset_cmd |=> cmd_pos == $past(home_ofs_ff) && act_pos == $past(home_ofs_ff)
        && home_set)
        else $error("preset did not load positions");
    wrap_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_step && cmd_dir && !preset_cmd && wrap_on && $signed(cmd_pos) == hi_ff
        |=> cmd_pos == $past(lo_ff))
        else $error("command position did not wrap");
    cfg_check_a: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_cmd |-> ##[1:250] chk_done)
        else $error("configuration did not run the check");
    op_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        wrap_active |-> profile_position_mode && op_code[3])
        else $error("wrap active outside wrap operation");
endmodule

// *** dv/wcg_far_side.sv ***
// far side model: sensor wrap values and a step pulse source
`timescale 1ns/100ps
module wcg_far_side (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic bad,
    input wire logic go,
    input wire logic dir,
    input wire logic [15:0] n,
    output logic [15:0] sens_range,
    output logic [13:0] sens_ratio,
    output logic [29:0] sens_offset,
    output logic step,
    output logic step_dir,
    output logic busy
);
    logic [15:0] left_ff;
    logic dir_ff;
    // good: 100.0 rev in tenths; bad: 1,000 rev, off the list on purpose
    assign sens_range = bad ? 16'h2710 : 16'h03e8;
    assign sens_ratio = 14'h1388;
    assign sens_offset = 30'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_ff <= 16'h0;
            dir_ff <= 1'b0;
        end else if (go) begin
            left_ff <= n;
            dir_ff <= dir;
        end else if (left_ff != 16'h0) begin
            left_ff <= left_ff - 16'h1;
        end
    end
    assign step = (left_ff != 16'h0);
    assign busy = step;
    // direction is meaningless between pulses, so scramble it there
    assign step_dir = step ? dir_ff : ~dir_ff;
endmodule

// *** dv/test_wcg_top.sv ***
// self-checking bench for the wrap coordinate generator
`timescale 1ns/100ps
`include "wcg_map.svh"
module test_wcg_top;
    import wcg_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ppm = 0;
    logic go = 0, dir = 0, bad = 0, pready, pslverr, step, step_dir, busy, e;
    logic [7:0] paddr = 0;
    logic [3:0] op_code = 0;
    logic [15:0] n = 0, s_range;
    logic [13:0] s_ratio;
    logic [29:0] s_offset;
    logic [31:0] pwdata = 0, prdata, cmd_pos, act_pos, q;
    logic wrap_active, err_info, err_alarm, home_set, irq;
    wcg_mode_e wrap_mode;
    logic [31:0] tr [5] = '{32'h2710, 32'h90, 32'h90, 32'h4650, 32'h4650};
    logic [31:0] tg [5] = '{32'h1, 32'h3, 32'h7, 32'h1, 32'h1};
    logic [31:0] tc [5] = '{32'h0c, 32'h0c, 32'h0c, 32'h1c, 32'h0c};
    logic [31:0] te [5] = '{32'h1, 32'h0, 32'h1, 32'h1, 32'h0};
    int errors = 0, n_compared = 0, cyc = 0;
    wcg_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .sens_range(s_range), .sens_ratio(s_ratio),
        .sens_offset(s_offset), .profile_position_mode(ppm), .op_code, .cmd_step(step),
        .cmd_dir(step_dir), .act_step(step), .act_dir(step_dir), .wrap_mode, .wrap_active,
        .err_info, .err_alarm, .home_set, .cmd_pos, .act_pos, .irq);
    wcg_far_side far (.pclk, .presetn, .bad, .go, .dir, .n, .sens_range(s_range),
        .sens_ratio(s_ratio), .sens_offset(s_offset), .step, .step_dir, .busy);
    initial begin
        forever #20 pclk = ~pclk;
    end
    task automatic stop_test();
        if (errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            errors++;
            $display("BAD %0t timeout", $time);
            stop_test();
        end
    end
    // callers sit on a falling edge, so the arguments are settled outputs
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        xfer(1'b0, a, 32'h0);
        chk(q & m, x);
    endtask
    // a retrigger mid-check costs a second run, about 400 cycles in all
    task automatic wt();
        repeat (450) @(negedge pclk);
    endtask
    task automatic steps(input logic [15:0] k, input logic d);
        @(posedge pclk);
        n <= k;
        dir <= d;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        @(posedge pclk);
        while (busy === 1'b1) @(posedge pclk);
        repeat (2) @(negedge pclk);
    endtask
    task automatic preset(input logic [31:0] h);
        wr(`WCG_HOME_OFS, h);
        wr(`WCG_CMD_OFS, 32'h2);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        wt();
        rdchk(`WCG_CTRL_OFS, 32'hff, 32'h08);
        rdchk(`WCG_RANGE_OFS, 32'hffff, 32'h0a);
        rdchk(`WCG_RATIO_OFS, 32'h3fff, 32'h1388);
        rdchk(`WCG_OFFSET_OFS, 32'hffffffff, 32'h0);
        rdchk(`WCG_STATUS_OFS, 32'h27, 32'h21);
        rdchk(8'h3c, 32'hffffffff, 32'h0);
        chk({31'h0, e}, 32'h1);
        for (int m = 0; m < 4; m++) begin
            wr(`WCG_CTRL_OFS, 32'h8 | m);
            chk(32'(wrap_mode), 32'(m));
        end
        wr(`WCG_RATIO_OFS, 32'h2711);
        rdchk(`WCG_RATIO_OFS, 32'h3fff, 32'h1388);
        wr(`WCG_RATIO_OFS, 32'h2710);
        rdchk(`WCG_RATIO_OFS, 32'h3fff, 32'h2710);
        wr(`WCG_OFFSET_OFS, 32'he0000000);
        rdchk(`WCG_OFFSET_OFS, 32'hffffffff, 32'he0000000);
        wr(`WCG_OFFSET_OFS, 32'h20000000);
        rdchk(`WCG_OFFSET_OFS, 32'hffffffff, 32'he0000000);
        wr(`WCG_OFFSET_OFS, 32'h1fffffff);
        rdchk(`WCG_OFFSET_OFS, 32'hffffffff, 32'h1fffffff);
        wr(`WCG_RATIO_OFS, 32'h1388);
        wr(`WCG_OFFSET_OFS, 32'h0);
        wr(`WCG_CTRL_OFS, 32'h0c);
        wr(`WCG_RANGE_OFS, 32'h5);
        wt();
        preset(32'h7);
        chk(cmd_pos, 32'h7);
        chk({act_pos[30:0], home_set}, 32'hf);
        for (int op = 0; op < 16; op++) begin
            @(posedge pclk);
            ppm <= 1'b1;
            op_code <= 4'(op);
            @(negedge pclk);
            chk(32'(wrap_active), 32'(op >= 8));
        end
        @(posedge pclk);
        ppm <= 1'b0;
        @(negedge pclk);
        chk(32'(wrap_active), 32'h0);
        @(posedge pclk);
        ppm <= 1'b1;
        preset(32'h0);
        steps(16'd2500, 1'b1);
        chk(cmd_pos, -32'sd2500);
        chk(act_pos, -32'sd2500);
        steps(16'd1, 1'b0);
        chk(cmd_pos, 32'd2499);
        steps(16'd2501, 1'b1);
        chk(cmd_pos, 32'h0);
        wr(`WCG_CTRL_OFS, 32'h04);
        wt();
        preset(32'h0);
        steps(16'd2500, 1'b1);
        chk(cmd_pos, 32'd2500);
        for (int i = 0; i < 5; i++) begin
            wr(`WCG_RANGE_OFS, tr[i]);
            wr(`WCG_GEAR_A_OFS, tg[i]);
            wr(`WCG_CTRL_OFS, tc[i]);
            wt();
            chk(32'(err_info), te[i]);
        end
        wr(`WCG_INT_EN_OFS, 32'h3);
        wr(`WCG_INT_CLR_OFS, 32'hf);
        wr(`WCG_RANGE_OFS, 32'h2710);
        wt();
        chk({err_info, irq, err_alarm}, 32'h6);
        wr(`WCG_INT_EN_OFS, 32'h0);
        chk(32'(irq), 32'h0);
        wr(`WCG_CMD_OFS, 32'h1);
        wt();
        chk(32'(err_alarm), 32'h1);
        rdchk(`WCG_INT_STAT_OFS, 32'h3, 32'h3);
        wr(`WCG_CMD_OFS, 32'h4);
        wr(`WCG_INT_CLR_OFS, 32'hf);
        wr(`WCG_INT_EN_OFS, 32'h3);
        chk({err_alarm, irq}, 32'h0);
        @(posedge pclk);
        bad <= 1'b1;
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        wt();
        chk({err_info, err_alarm}, 32'h3);
        stop_test();
    end
endmodule
